// >>> hw/gsc_handler.sv
// GPIO settings command handler: decodes 64-byte request reports byte by
// byte and streams a 64-byte response. Assumes requests arrive in order.
//
// Overview of operation
// - Byte 17 bit 4 sets remote wake-up enable.
// - Byte 17 bits 3..1 select interrupt counting mode; 5..7 reserved.
// - Byte 17 bit 0 set keeps SPI bus between transfers.
// - Response byte 0 echoes the request command code.
// - Status byte 1 is zero on success.
// - Code 0x33 returns current directions; host zeroes rest.
// - Direction word in bytes 4 and 5, pin 0 at LSB.
// - Code 0x32 loads directions from byte 4 only, echoes code.
// - Direction set changes only GPIO-designated pins; level reads report every pin.
// - Code 0x31 returns current pin levels.
// - Level response byte 4 holds pins 0 to 7 levels.
// - Level response byte 5 bit 0 is input-only pin 8 level.
// - Designation 0 GPIO, 1 chip select, 2 dedicated; pin 8 input or dedicated.
`default_nettype none
module gsc_handler #(
	parameter int NPINS = 8
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_b,
	input  wire logic             req_valid,
	input  wire logic [7:0]       req_data,
	input  wire logic             resp_ready,
	output logic                  resp_valid,
	output logic      [7:0]       resp_data,
	output logic                  resp_last,
	output logic                  req_ready,
	input  wire logic [NPINS-1:0] gp_pin_in,
	input  wire logic             input_only_pin,
	output logic      [NPINS-1:0] gp_dir,
	output logic      [NPINS-1:0] gp_is_gpio,
	output logic                  input_only_dedicated,
	output logic                  remote_wake_en,
	output logic      [2:0]       int_count_mode,
	output logic                  spi_hold_bus
);
	typedef enum logic [2:0] {
		GSC_RX   = 3'b001,
		GSC_FILL = 3'b010,
		GSC_TX   = 3'b100
	} gsc_state_t;

	// ==========================================================
	// Pin synchronisers: three stages, change taken when 2 and 3 agree
	logic [NPINS:0] s1_reg, s2_reg, s3_reg, lvl_reg;
	logic [NPINS:0] lvl_next;
	always_comb begin
		lvl_next = lvl_reg;
		for (int i = 0; i <= NPINS; i++) begin
			if (s2_reg[i] == s3_reg[i]) begin
				lvl_next[i] = s3_reg[i];
			end
		end
	end
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_reg  <= '0;
			s2_reg  <= '0;
			s3_reg  <= '0;
			lvl_reg <= '0;
		end else begin
			s1_reg  <= {input_only_pin, gp_pin_in};
			s2_reg  <= s1_reg;
			s3_reg  <= s2_reg;
			lvl_reg <= lvl_next;
		end
	end

	// ==========================================================
	// Command state
	gsc_state_t       st_reg, st_next;
	logic [5:0]       idx_reg, idx_next;
	logic [7:0]       cmd_reg, cmd_next;
	logic [7:0]       wlo_reg, wlo_next;
	logic [NPINS-1:0] dir_reg, dir_next;
	logic [NPINS-1:0] gpio_reg, gpio_next;
	logic             p8d_reg, p8d_next;
	logic             wake_reg, wake_next;
	logic [2:0]       mode_reg, mode_next;
	logic             hold_reg, hold_next;
	logic             mem_we;
	logic [7:0]       mem_wd;
	logic [7:0]       mem_rd;
	logic             txv_reg, txv_next;

	// Response byte for a given index; zero except code, status, direction and level bytes
	function automatic logic [7:0] resp_byte(input logic [5:0] idx, input logic [7:0] cmd,
			input logic [NPINS-1:0] dir, input logic [NPINS:0] lvl);
		logic [7:0] b;
		b = gsc_pkg::BYTE_ZERO;
		if (idx == gsc_pkg::IDX_CMD) begin
			b = cmd;
		end else if (idx == gsc_pkg::IDX_STATUS) begin
			b = (cmd == gsc_pkg::CMD_SET_SETTINGS || cmd == gsc_pkg::CMD_GET_LEVEL ||
				cmd == gsc_pkg::CMD_SET_DIR || cmd == gsc_pkg::CMD_GET_DIR) ?
				gsc_pkg::STATUS_OK : gsc_pkg::CMD_UNKNOWN_ST;
		end else if (cmd == gsc_pkg::CMD_GET_DIR && idx == gsc_pkg::IDX_WORD_LO) begin
			// direction word, pin 0 at LSB
			b = 8'(dir);
		end else if (cmd == gsc_pkg::CMD_GET_DIR && idx == gsc_pkg::IDX_WORD_HI) begin
			// high byte, pin 8 always input
			b = 8'h01;
		end else if (cmd == gsc_pkg::CMD_GET_LEVEL && idx == gsc_pkg::IDX_WORD_LO) begin
			b = 8'(lvl[NPINS-1:0]);
		end else if (cmd == gsc_pkg::CMD_GET_LEVEL && idx == gsc_pkg::IDX_WORD_HI) begin
			// pin 8 level in bit 0
			b = {7'h00, lvl[NPINS]};
		end
		return b;
	endfunction

	// ==========================================================
	// Next-state logic for receive, fill and transmit
	always_comb begin
		st_next   = st_reg;
		idx_next  = idx_reg;
		cmd_next  = cmd_reg;
		wlo_next  = wlo_reg;
		dir_next  = dir_reg;
		gpio_next = gpio_reg;
		p8d_next  = p8d_reg;
		wake_next = wake_reg;
		mode_next = mode_reg;
		hold_next = hold_reg;
		txv_next  = 1'b0;
		mem_we    = 1'b0;
		mem_wd    = gsc_pkg::BYTE_ZERO;
		unique case (st_reg)
			GSC_RX: begin
				if (req_valid) begin
					// only indexed bytes are kept, reserved ones dropped
					if (idx_reg == gsc_pkg::IDX_CMD) begin
						cmd_next = req_data;
					end
					if (idx_reg == gsc_pkg::IDX_WORD_LO) begin
						wlo_next = req_data;
					end
					// designation bytes 4..11 of settings report
					if (cmd_reg == gsc_pkg::CMD_SET_SETTINGS && idx_reg >= gsc_pkg::IDX_DESIG_FIRST &&
						idx_reg < gsc_pkg::IDX_DESIG_LAST) begin
						gpio_next[3'(idx_reg - gsc_pkg::IDX_DESIG_FIRST)] = (req_data == gsc_pkg::DESIG_GPIO);
					end
					// pin 8 input or dedicated only
					if (cmd_reg == gsc_pkg::CMD_SET_SETTINGS && idx_reg == gsc_pkg::IDX_DESIG_LAST) begin
						p8d_next = (req_data == gsc_pkg::DESIG_DEDICATED);
					end
					if (cmd_reg == gsc_pkg::CMD_SET_SETTINGS && idx_reg == gsc_pkg::IDX_OTHER) begin
						wake_next = req_data[gsc_pkg::BIT_WAKE];
						mode_next = req_data[gsc_pkg::BIT_MODE_HI:gsc_pkg::BIT_MODE_LO];
						hold_next = req_data[gsc_pkg::BIT_SPI_HOLD];
					end
					idx_next = idx_reg + 6'h01;
					if (idx_reg == gsc_pkg::IDX_LAST) begin
						st_next  = GSC_FILL;
						idx_next = gsc_pkg::IDX_CMD;
					end
				end
			end
			GSC_FILL: begin
				// apply new directions once the report is complete
				if (idx_reg == gsc_pkg::IDX_CMD && cmd_reg == gsc_pkg::CMD_SET_DIR) begin
					dir_next = (dir_reg & ~gpio_reg) | (wlo_reg[NPINS-1:0] & gpio_reg);
				end
				mem_we   = 1'b1;
				mem_wd   = resp_byte(idx_reg, cmd_reg, dir_reg, lvl_reg);
				idx_next = idx_reg + 6'h01;
				if (idx_reg == gsc_pkg::IDX_LAST) begin
					st_next  = GSC_TX;
					idx_next = gsc_pkg::IDX_CMD;
					// Valid waits one cycle so the read of byte 0 can land
				end
			end
			GSC_TX: begin
				txv_next = 1'b1;
				// Registered read lags one cycle, so advance only on acceptance
				if (txv_reg && resp_ready) begin
					idx_next = idx_reg + 6'h01;
					txv_next = 1'b0;
					if (idx_reg == gsc_pkg::IDX_LAST) begin
						st_next  = GSC_RX;
						idx_next = gsc_pkg::IDX_CMD;
					end
				end
			end
		endcase
	end

	// ==========================================================
	// State registers
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg   <= GSC_RX;
			idx_reg  <= 6'h00;
			cmd_reg  <= 8'h00;
			wlo_reg  <= 8'h00;
			dir_reg  <= gsc_pkg::DIR_RESET;
			gpio_reg <= '1;
			p8d_reg  <= 1'b0;
			wake_reg <= 1'b0;
			mode_reg <= gsc_pkg::MODE_NONE;
			hold_reg <= 1'b0;
			txv_reg  <= 1'b0;
		end else begin
			st_reg   <= st_next;
			idx_reg  <= idx_next;
			cmd_reg  <= cmd_next;
			wlo_reg  <= wlo_next;
			dir_reg  <= dir_next;
			gpio_reg <= gpio_next;
			p8d_reg  <= p8d_next;
			wake_reg <= wake_next;
			mode_reg <= mode_next;
			hold_reg <= hold_next;
			txv_reg  <= txv_next;
		end
	end

	gsc_resp_mem #(
		.DEPTH (gsc_pkg::REPORT_LEN),
		.AW    (6)
	) u_mem (
		.sys_clk (sys_clk),
		.wr_en   (mem_we),
		.wr_addr (idx_reg),
		.wr_data (mem_wd),
		.rd_addr (idx_reg),
		.rd_data (mem_rd)
	);

	// ==========================================================
	// Outputs
	assign req_ready            = (st_reg == GSC_RX);
	assign resp_valid           = (st_reg == GSC_TX) && txv_reg;
	assign resp_data            = mem_rd;
	assign resp_last            = resp_valid && (idx_reg == gsc_pkg::IDX_LAST);
	assign gp_dir               = dir_reg;
	assign gp_is_gpio           = gpio_reg;
	assign input_only_dedicated = p8d_reg;
	assign remote_wake_en       = wake_reg;
	assign int_count_mode       = mode_reg;
	assign spi_hold_bus         = hold_reg;

	// ==========================================================
	// Checks
	sequence s_settings_byte;
		st_reg == GSC_RX && req_valid && cmd_reg == gsc_pkg::CMD_SET_SETTINGS && idx_reg == gsc_pkg::IDX_OTHER;
	endsequence
	sequence s_tx_first;
		resp_valid && idx_reg == gsc_pkg::IDX_CMD;
	endsequence

	AST_WAKE: assert property (@(posedge sys_clk) disable iff (!rst_b)
		s_settings_byte |=> remote_wake_en == $past(req_data[gsc_pkg::BIT_WAKE]))
		else $error("wake enable not taken");
	AST_MODE: assert property (@(posedge sys_clk) disable iff (!rst_b)
		s_settings_byte |=> int_count_mode == $past(req_data[3:1]))
		else $error("count mode not taken");
	AST_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
		s_settings_byte |=> spi_hold_bus == $past(req_data[0]))
		else $error("spi hold not taken");
	AST_ECHO: assert property (@(posedge sys_clk) disable iff (!rst_b)
		s_tx_first |-> resp_data == cmd_reg)
		else $error("code not echoed");
	AST_STATUS: assert property (@(posedge sys_clk) disable iff (!rst_b)
		resp_valid && idx_reg == gsc_pkg::IDX_STATUS && cmd_reg == gsc_pkg::CMD_GET_DIR |-> resp_data == gsc_pkg::STATUS_OK)
		else $error("status not ok");
	AST_DIR_WORD: assert property (@(posedge sys_clk) disable iff (!rst_b)
		resp_valid && idx_reg == gsc_pkg::IDX_WORD_LO && cmd_reg == gsc_pkg::CMD_GET_DIR |-> resp_data == gp_dir)
		else $error("direction word wrong");
	AST_DIR_MASK: assert property (@(posedge sys_clk) disable iff (!rst_b)
		$changed(gp_dir) |-> (($past(gp_dir) ^ gp_dir) & ~gp_is_gpio) == '0)
		else $error("non-gpio pin changed direction");
	AST_LVL_HI: assert property (@(posedge sys_clk) disable iff (!rst_b)
		resp_valid && idx_reg == gsc_pkg::IDX_WORD_HI && cmd_reg == gsc_pkg::CMD_GET_LEVEL |-> resp_data[7:1] == 7'h00)
		else $error("level high byte wrong");
	AST_TX_DONE: assert property (@(posedge sys_clk) disable iff (!rst_b)
		resp_last && resp_ready |=> req_ready)
		else $error("did not return to receive");
	AST_DIR_KEEP: assert property (@(posedge sys_clk) disable iff (!rst_b)
		$changed(gp_dir) |-> $past(st_reg) == GSC_FILL && $past(cmd_reg) == gsc_pkg::CMD_SET_DIR)
		else $error("direction changed outside a set command");
	AST_STATUS_ALL: assert property (@(posedge sys_clk) disable iff (!rst_b)
		resp_valid && idx_reg == gsc_pkg::IDX_STATUS && (cmd_reg == gsc_pkg::CMD_SET_SETTINGS ||
		cmd_reg == gsc_pkg::CMD_GET_LEVEL || cmd_reg == gsc_pkg::CMD_SET_DIR) |-> resp_data == gsc_pkg::STATUS_OK)
		else $error("status not ok for known command");
	AST_RESP_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
		resp_valid && !resp_ready |=> resp_valid && $stable(resp_data))
		else $error("response byte dropped before acceptance");
endmodule
`default_nettype wire

// >>> hw/gsc_resp_mem.sv
// Response report buffer: 64 bytes, one write port, registered read.
// Assumes writer and reader share sys_clk.
`default_nettype none
module gsc_resp_mem #(
	parameter int DEPTH = 64,
	parameter int AW    = 6
) (
	input  wire logic          sys_clk,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [7:0]    wr_data,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [7:0]    rd_data
);
	logic [7:0] mem_reg [DEPTH];

	// ==========================================================
	// Storage; no reset so it maps to RAM
	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			mem_reg[wr_addr] <= wr_data;
		end
		rd_data <= mem_reg[rd_addr];
	end
endmodule
`default_nettype wire

// >>> pkg/gsc_pkg.sv
// Shared constants for the GPIO settings command handler.
// Assumes a byte-serial 64-byte report stream on one clock.
`default_nettype none
package gsc_pkg;
	localparam int          REPORT_LEN      = 64;
	localparam logic [7:0]  CMD_SET_SETTINGS = 8'h21;
	localparam logic [7:0]  CMD_GET_LEVEL   = 8'h31;
	localparam logic [7:0]  CMD_SET_DIR     = 8'h32;
	localparam logic [7:0]  CMD_GET_DIR     = 8'h33;
	localparam logic [7:0]  STATUS_OK       = 8'h00;
	localparam logic [7:0]  CMD_UNKNOWN_ST  = 8'hF9;
	localparam logic [5:0]  IDX_CMD         = 6'h00;
	localparam logic [5:0]  IDX_STATUS      = 6'h01;
	localparam logic [5:0]  IDX_DESIG_FIRST = 6'h04;
	localparam logic [5:0]  IDX_DESIG_LAST  = 6'h0C;
	localparam logic [5:0]  IDX_WORD_LO     = 6'h04;
	localparam logic [5:0]  IDX_WORD_HI     = 6'h05;
	localparam logic [5:0]  IDX_OTHER       = 6'h11;
	localparam logic [5:0]  IDX_LAST        = 6'h3F;
	localparam int          BIT_WAKE        = 4;
	localparam int          BIT_MODE_HI     = 3;
	localparam int          BIT_MODE_LO     = 1;
	localparam int          BIT_SPI_HOLD    = 0;
	localparam logic [7:0]  DESIG_GPIO      = 8'h00;
	localparam logic [7:0]  DESIG_CS        = 8'h01;
	localparam logic [7:0]  DESIG_DEDICATED = 8'h02;
	localparam logic [2:0]  MODE_NONE       = 3'h0;
	localparam logic [2:0]  MODE_FALL       = 3'h1;
	localparam logic [2:0]  MODE_RISE       = 3'h2;
	localparam logic [2:0]  MODE_LOW_PULSE  = 3'h3;
	localparam logic [2:0]  MODE_HIGH_PULSE = 3'h4;
	localparam logic [7:0]  DIR_RESET       = 8'hFF;
	localparam logic [7:0]  BYTE_ZERO       = 8'h00;
endpackage
`default_nettype wire

// >>> tb/gsc_host_model.sv
// Host-side model: sends 64-byte request reports and collects responses.
// Assumes the handler contract: level valid, byte taken while req_ready.
`default_nettype none
module gsc_host_model (
	input  wire logic       sys_clk,
	input  wire logic       req_ready,
	input  wire logic       resp_valid,
	input  wire logic [7:0] resp_data,
	input  wire logic       resp_last,
	output var  logic       req_valid,
	output var  logic [7:0] req_data,
	output var  logic       resp_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] req_buf [64];
	logic [7:0] resp_buf [64];
	logic [7:0] last_pos;

	// ==========================================================
	// Idle levels
	initial begin
		req_valid = 1'b0;
		req_data = 8'h00;
		resp_ready = 1'b0;
	end

	// ==========================================================
	// Report preparation
	// unused bytes zero
	task automatic prep(input logic [7:0] cmd);
		for (int i = 0; i < 64; i++) req_buf[i] = 8'h00;
		req_buf[0] = cmd;
	endtask

	// ==========================================================
	// One request then one response; slow stalls the sink
	task automatic xfer(input logic slow);
		int n;
		int cyc;
		for (int i = 0; i < 64; i++) begin
			@(negedge sys_clk);
			req_valid = 1'b1;
			req_data = req_buf[i];
			// Byte is taken at the next edge once ready is seen
			while (req_ready !== 1'b1) @(negedge sys_clk);
		end
		@(negedge sys_clk);
		req_valid = 1'b0;
		req_data = ~req_data; // Released bus must not look valid
		n = 0;
		cyc = 0;
		last_pos = 8'hFF;
		while (n < 64) begin
			@(negedge sys_clk);
			resp_ready = slow ? cyc[1] : 1'b1;
			cyc++;
			if (resp_valid === 1'b1 && resp_ready) begin
				resp_buf[n] = resp_data;
				if (resp_last === 1'b1) last_pos = n[7:0];
				n++;
			end
		end
		@(negedge sys_clk);
		resp_ready = 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Testbench for the GPIO settings command handler.
// Assumes the host model drives the request and response handshakes.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       sys_clk;
	logic       rst_b;
	logic [7:0] gp_pin_in;
	logic       input_only_pin;
	logic       req_valid, req_ready, resp_valid, resp_ready, resp_last;
	logic [7:0] req_data, resp_data, gp_dir, gp_is_gpio;
	logic       input_only_dedicated, remote_wake_en, spi_hold_bus;
	logic [2:0] int_count_mode;
	logic [7:0] b17;
	int         failures = 0;
	int         n_compared = 0;
	int         cycles = 0;

	gsc_handler #(.NPINS(8)) u_gsc_handler (.sys_clk(sys_clk), .rst_b(rst_b), .req_valid(req_valid),
		.req_data(req_data), .resp_ready(resp_ready), .resp_valid(resp_valid), .resp_data(resp_data),
		.resp_last(resp_last), .req_ready(req_ready), .gp_pin_in(gp_pin_in), .input_only_pin(input_only_pin),
		.gp_dir(gp_dir), .gp_is_gpio(gp_is_gpio), .input_only_dedicated(input_only_dedicated),
		.remote_wake_en(remote_wake_en), .int_count_mode(int_count_mode), .spi_hold_bus(spi_hold_bus));
	gsc_host_model u_gsc_host_model (.sys_clk(sys_clk), .req_ready(req_ready), .resp_valid(resp_valid),
		.resp_data(resp_data), .resp_last(resp_last), .req_valid(req_valid), .req_data(req_data),
		.resp_ready(resp_ready));

	// ==========================================================
	// Clock and hang guard; ceiling well above eleven transfers
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			$display("[FAIL] run length expected below %0d seen %0d", 20000, cycles);
			summarize();
		end
	end

	// ==========================================================
	// Compare and report helpers
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic go(input logic slow, input logic [7:0] st);
		u_gsc_host_model.xfer(slow);
		chk("echoed code", u_gsc_host_model.req_buf[0], u_gsc_host_model.resp_buf[0]);
		chk("status byte", st, u_gsc_host_model.resp_buf[1]);
		chk("last flag index", 8'h3F, u_gsc_host_model.last_pos);
	endtask
	task automatic summarize;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ==========================================================
	// Main sequence; pin 2 chip select and pin 6 dedicated give mask BB
	initial begin
		rst_b = 1'b0;
		gp_pin_in = 8'h00;
		input_only_pin = 1'b0;
		repeat (20) @(negedge sys_clk);
		rst_b = 1'b1;
		chk("dir after reset", 8'hFF, gp_dir);
		chk("settings after reset", 8'h00, {3'h0, remote_wake_en, int_count_mode, spi_hold_bus});
		$display("test reset done");
		for (int m = 0; m < 5; m++) begin
			u_gsc_host_model.prep(8'h21);
			for (int i = 0; i < 8; i++)
				u_gsc_host_model.req_buf[4 + i] = (i == 2) ? gsc_pkg::DESIG_CS :
					(i == 6) ? gsc_pkg::DESIG_DEDICATED : gsc_pkg::DESIG_GPIO;
			u_gsc_host_model.req_buf[12] = (m == 3) ? gsc_pkg::DESIG_DEDICATED : gsc_pkg::DESIG_GPIO;
			// Upper three bits are don't care and set on purpose
			b17 = {3'h7, m[0], m[2:0], ~m[0]};
			u_gsc_host_model.req_buf[17] = b17;
			go(m[0], 8'h00);
			chk("settings fields", b17 & 8'h1F, {3'h0, remote_wake_en, int_count_mode, spi_hold_bus});
			chk("gpio mask", 8'hBB, gp_is_gpio);
			chk("pin 8 dedicated", {7'h00, m == 3}, {7'h00, input_only_dedicated});
		end
		$display("test settings done");
		u_gsc_host_model.prep(8'h32);
		u_gsc_host_model.req_buf[4] = 8'h5A;
		u_gsc_host_model.req_buf[5] = 8'h01;
		go(1'b1, 8'h00);
		chk("dir after set", 8'h5E, gp_dir);
		u_gsc_host_model.prep(8'h33);
		go(1'b0, 8'h00);
		chk("dir word low", 8'h1A, u_gsc_host_model.resp_buf[4] & 8'hBB);
		$display("test direction done");
		for (int k = 0; k < 2; k++) begin
			gp_pin_in = 8'hA5 ^ 8'(k * 8'h99);
			input_only_pin = ~k[0];
			repeat (8) @(negedge sys_clk);
			u_gsc_host_model.prep(8'h31);
			go(k[0], 8'h00);
			chk("level low", gp_pin_in & 8'hBB, u_gsc_host_model.resp_buf[4] & 8'hBB);
			chk("level pin 8", {7'h00, ~k[0]}, {7'h00, u_gsc_host_model.resp_buf[5][0]});
		end
		$display("test levels done");
		u_gsc_host_model.prep(8'h40);
		go(1'b0, gsc_pkg::CMD_UNKNOWN_ST);
		$display("test unknown code done");
		// Reset in mid-run must restore every default
		@(negedge sys_clk);
		rst_b = 1'b0;
		repeat (2) @(negedge sys_clk);
		rst_b = 1'b1;
		chk("dir after second reset", 8'hFF, gp_dir);
		chk("gpio mask after reset", 8'hFF, gp_is_gpio);
		chk("settings after second reset", 8'h00,
			{2'h0, input_only_dedicated, remote_wake_en, int_count_mode, spi_hold_bus});
		u_gsc_host_model.prep(8'h33);
		go(1'b0, 8'h00);
		chk("dir word after reset", 8'hFF, u_gsc_host_model.resp_buf[4]);
		$display("test second reset done");
		summarize();
	end
endmodule
`default_nettype wire
